// [asu_pkg.sv]
// Package of constants and types for the asynchronous serial UART
package asu_pkg;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] START_WAIT = 4'h7;
  localparam logic [3:0] AUTO_POS = 4'h7;
  localparam logic [4:0] PSC_STOP = 5'h00;
  localparam logic [1:0] FMT_7 = 2'h0;
  localparam logic [1:0] FMT_8 = 2'h1;
  localparam logic [1:0] FMT_9 = 2'h2;
  localparam logic [3:0] BITS_7 = 4'h7;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  localparam logic [7:0] RST_DATA = 8'h00;

  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA = 4'b0100,
    TX_STOP = 4'b1000
  } asu_tx_st_t;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } asu_rx_st_t;
endpackage : asu_pkg

// [asu_baud_gen.sv]
// Two-stage baud generator: half-step prescaler then 11-bit divisor
`timescale 1ns/1ps
`default_nettype none
module asu_baud_gen (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [4:0] prescaler_select,
  input wire logic [10:0] baud_divisor,
  output logic os_tick
);
  import asu_pkg::*;

  typedef struct packed {
    logic [5:0] pre_cnt;
    logic [10:0] div_cnt;
    logic tick;
  } asu_bg_t;

  asu_bg_t s_r;
  asu_bg_t s_nxt;
  logic [5:0] pre_lim;

  // Factor is code/2+0.5, so count in half steps: code+1 half cycles
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    pre_lim = {1'b0, prescaler_select} + 6'h01;
    if (prescaler_select == PSC_STOP) // RULE18
    begin
      s_nxt.pre_cnt = 6'h00;
      s_nxt.div_cnt = 11'h000;
    end
    else if (s_r.pre_cnt + 6'h02 >= pre_lim) // RULE17
    begin
      s_nxt.pre_cnt = 6'((s_r.pre_cnt + 6'h02) - pre_lim);
      if (s_r.div_cnt >= baud_divisor) // RULE19
      begin
        s_nxt.div_cnt = 11'h000;
        s_nxt.tick = 1'b1;
      end
      else
      begin
        s_nxt.div_cnt = s_r.div_cnt + 11'h001;
      end
    end
    else
    begin
      s_nxt.pre_cnt = s_r.pre_cnt + 6'h02;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign os_tick = s_r.tick;
endmodule : asu_baud_gen
`default_nettype wire

// [asu_uart.sv]
// Asynchronous serial UART with double-buffered transmit and receive
// What this block does
// RULE1: After last stop bit, holding buffer moves to shift register; empty flag sets; LSB first.
// RULE2: Writing the holding buffer clears the holding-empty flag.
// RULE3: In-progress flag stays high until last stop sent and holding buffer empty.
// RULE4: Sixteen oversample ticks per bit, from the baud generator.
// RULE5: After low input, wait seven ticks, three samples all low accept start.
// RULE6: Each later bit is a majority vote of three mid-bit samples.
// RULE7: Sample position automatic unless manual select, then programmed position.
// RULE8: Complete character loads holding buffer, sets full flag; read clears it.
// RULE9: Attention mode drops characters until ninth bit is one.
// RULE10: Address character loads buffer, sets full, interrupt, clears attention wait.
// RULE11: Transmitter unaffected by attention; ninth bits via separate control and status. Code drops transmit parity while attention_mode is set.
// RULE12: Diagnostic mode loops transmit into receive, 9-bit no parity only.
// RULE13: 7-bit format: start, seven data, optional parity, one or two stops.
// RULE14: 8-bit format: start, eight data, optional parity, one or two stops.
// RULE15: 9-bit format uses eight bits plus ninth bit; never parity.
// RULE16: Flag parity, framing and overrun errors.
// RULE17: Baud clock through 5-bit prescaler then 11-bit divisor.
// RULE18: Prescaler code zero stops clock; others divide 1 to 16 in half steps.
// RULE19: Baud equals clock over oversample times divisor plus one times prescaler.
// RULE20: Software stops the prescaler before changing baud rate.
// RULE21: Clear-to-send deasserted halts transmission after the current frame.
// RULE22: Request-to-send asserted when ready to send a character.
// RULE23: Transmit interrupt while holding-empty and its enable are set.
// RULE24: Receive interrupt while full flag and its enable are set.
// RULE25: Character completing while full sets overrun and keeps old buffer.
`timescale 1ns/1ps
`default_nettype none
module asu_uart (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic rxd,
  output logic txd,
  input wire logic cts_n,
  output logic rts_n,
  input wire logic [4:0] prescaler_select,
  input wire logic [10:0] baud_divisor,
  input wire logic [1:0] data_format,
  input wire logic parity_enable,
  input wire logic parity_odd,
  input wire logic two_stop,
  input wire logic attention_mode,
  input wire logic attention_set,
  input wire logic diag_mode,
  input wire logic manual_sample_select,
  input wire logic [3:0] sample_position_reg,
  input wire logic tx_ninth_bit,
  input wire logic [7:0] tx_wdata,
  input wire logic tx_write,
  input wire logic rx_read,
  input wire logic err_clear,
  input wire logic tx_irq_enable,
  input wire logic rx_irq_enable,
  output logic [7:0] rx_holding_buffer,
  output logic rx_ninth_bit,
  output logic rx_full_flag,
  output logic tx_holding_empty_flag,
  output logic tx_in_progress_flag,
  output logic attention_wait_flag,
  output logic parity_err,
  output logic framing_err,
  output logic overrun_err,
  output logic tx_irq,
  output logic rx_irq
);
  import asu_pkg::*;

  typedef struct packed {
    logic rx_m;
    logic rx_s;
    logic cts_m;
    logic cts_s;
    asu_tx_st_t tst;
    logic [8:0] tx_shift_reg;
    logic tx_par;
    logic tx_par_sent;
    logic [3:0] tx_os;
    logic [3:0] tx_bit;
    logic tx_stop2;
    logic tx_line;
    logic [7:0] tx_holding_buffer;
    logic thbe;
    logic tip;
    asu_rx_st_t rst_st;
    logic [9:0] rx_shift_reg;
    logic [3:0] rx_os;
    logic [3:0] rx_bit;
    logic [2:0] smp;
    logic [7:0] rbuf;
    logic rb9;
    logic rbf;
    logic atn;
    logic pe;
    logic fe;
    logic oe;
  } asu_st_t;

  asu_st_t s_r;
  asu_st_t s_nxt;
  logic os_tick;
  logic rx_in;
  logic [1:0] fmt;
  logic [3:0] nbits;
  logic use_par;
  logic [3:0] pos;
  logic vote;
  logic [3:0] tot_bits;
  logic par_calc;

  asu_baud_gen u_baud (
    .core_clk(core_clk),
    .rst(rst),
    .prescaler_select(prescaler_select),
    .baud_divisor(baud_divisor),
    .os_tick(os_tick) // RULE4
  );

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rx_m = rxd;
    s_nxt.rx_s = s_r.rx_m;
    s_nxt.cts_m = cts_n;
    s_nxt.cts_s = s_r.cts_m;
    fmt = diag_mode ? FMT_9 : data_format; // RULE12
    nbits = (fmt == FMT_7) ? BITS_7 : ((fmt == FMT_8) ? BITS_8 : BITS_9); // RULE13 RULE14
    use_par = parity_enable && (fmt != FMT_9) && !attention_mode && !diag_mode; // RULE15
    tot_bits = use_par ? nbits + 4'h1 : nbits;
    pos = manual_sample_select ? sample_position_reg : AUTO_POS; // RULE7
    rx_in = diag_mode ? s_r.tx_line : s_r.rx_s; // RULE12
    vote = (s_r.smp[0] & s_r.smp[1]) | (s_r.smp[1] & s_r.smp[2])
      | (s_r.smp[0] & s_r.smp[2]); // RULE6
    par_calc = 1'b0;

    // Software side: holding buffers, attention set and error clear
    if (tx_write)
    begin
      s_nxt.tx_holding_buffer = tx_wdata;
      s_nxt.thbe = 1'b0; // RULE2
      s_nxt.tip = 1'b1;
    end
    if (attention_set)
    begin
      s_nxt.atn = 1'b1;
    end
    if (rx_read)
    begin
      s_nxt.rbf = 1'b0; // RULE8
    end
    if (err_clear)
    begin
      s_nxt.pe = 1'b0;
      s_nxt.fe = 1'b0;
      s_nxt.oe = 1'b0;
    end

    // Transmitter
    if (os_tick)
    begin
      s_nxt.tx_os = s_r.tx_os + 4'h1;
      case (s_r.tst)
        TX_IDLE:
        begin
          s_nxt.tx_os = 4'h0;
          s_nxt.tx_line = 1'b1;
          if (!s_r.thbe && !s_r.cts_s) // RULE21
          begin
            s_nxt.tx_shift_reg = {tx_ninth_bit, s_r.tx_holding_buffer}; // RULE11
            s_nxt.thbe = !tx_write; // RULE1
            s_nxt.tip = 1'b1; // RULE3
            s_nxt.tx_line = 1'b0;
            s_nxt.tx_bit = 4'h0;
            s_nxt.tx_par = parity_odd;
            s_nxt.tx_par_sent = 1'b0;
            s_nxt.tst = TX_START;
          end
        end
        TX_START:
        begin
          if (s_r.tx_os == OVS_LAST)
          begin
            s_nxt.tx_line = s_r.tx_shift_reg[0]; // RULE1
            s_nxt.tst = TX_DATA;
          end
        end
        TX_DATA:
        begin
          if (s_r.tx_os == OVS_LAST)
          begin
            s_nxt.tx_bit = s_r.tx_bit + 4'h1;
            if (s_r.tx_bit < nbits)
            begin
              s_nxt.tx_par = s_r.tx_par ^ s_r.tx_shift_reg[0];
              s_nxt.tx_shift_reg = {1'b0, s_r.tx_shift_reg[8:1]};
            end
            if (s_r.tx_bit + 4'h1 < nbits)
            begin
              s_nxt.tx_line = s_r.tx_shift_reg[1];
            end
            else if (s_r.tx_bit + 4'h1 == nbits && use_par)
            begin
              s_nxt.tx_line = s_r.tx_par ^ s_r.tx_shift_reg[0];
            end
            else
            begin
              s_nxt.tx_line = 1'b1;
              s_nxt.tx_stop2 = two_stop;
              s_nxt.tst = TX_STOP;
            end
          end
        end
        TX_STOP:
        begin
          if (s_r.tx_os == OVS_LAST)
          begin
            if (s_r.tx_stop2)
            begin
              s_nxt.tx_stop2 = 1'b0;
            end
            else if (!s_r.thbe && !s_r.cts_s) // RULE1 RULE21
            begin
              s_nxt.tx_shift_reg = {tx_ninth_bit, s_r.tx_holding_buffer};
              s_nxt.thbe = !tx_write;
              s_nxt.tx_line = 1'b0;
              s_nxt.tx_bit = 4'h0;
              s_nxt.tx_par = parity_odd;
              s_nxt.tst = TX_START;
            end
            else
            begin
              s_nxt.tip = !s_r.thbe || tx_write; // RULE3
              s_nxt.tst = TX_IDLE;
            end
          end
        end
        default:
        begin
          s_nxt.tst = TX_IDLE;
        end
      endcase
    end

    // Receiver
    if (os_tick)
    begin
      s_nxt.rx_os = s_r.rx_os + 4'h1;
      if (s_r.rx_os == pos || s_r.rx_os == pos + 4'h1 || s_r.rx_os == pos + 4'h2)
      begin
        s_nxt.smp = {rx_in, s_r.smp[2:1]};
      end
      case (s_r.rst_st)
        RX_IDLE:
        begin
          s_nxt.rx_os = 4'h0;
          if (!rx_in)
          begin
            s_nxt.rx_os = 4'h1;
            s_nxt.rst_st = RX_START;
          end
        end
        RX_START:
        begin
          // Samples at ticks 7..9 after the falling edge, 6..8 for a manual position outside 7..9
          if (s_r.rx_os == START_WAIT + 4'h3 && s_r.smp != 3'b000) // RULE5
          begin
            s_nxt.rst_st = RX_IDLE;
          end
          // Data slots begin where the start bit ends
          if (s_r.rx_os == OVS_LAST)
          begin
            s_nxt.rst_st = RX_DATA;
            s_nxt.rx_bit = 4'h0;
          end
          if (s_r.rx_os == START_WAIT - 4'h1 || s_r.rx_os == START_WAIT
            || s_r.rx_os == START_WAIT + 4'h1)
          begin
            s_nxt.smp = {rx_in, s_r.smp[2:1]};
          end
          else
          begin
            s_nxt.smp = s_nxt.smp;
          end
        end
        RX_DATA:
        begin
          // Vote once the third sample of this bit is registered
          if (s_r.rx_os == pos + 4'h3)
          begin
            s_nxt.rx_shift_reg = {vote, s_r.rx_shift_reg[9:1]};
            s_nxt.rx_bit = s_r.rx_bit + 4'h1;
            if (s_r.rx_bit + 4'h1 == tot_bits)
            begin
              s_nxt.rst_st = RX_STOP;
            end
          end
        end
        RX_STOP:
        begin
          if (s_r.rx_os == pos + 4'h3)
          begin
            s_nxt.rst_st = RX_IDLE;
            s_nxt.rx_os = 4'h0;
            for (int i = 0; i < 10; i++)
            begin
              if (i < int'(tot_bits))
              begin
                par_calc = par_calc ^ s_r.rx_shift_reg[4'(10 - int'(tot_bits) + i)];
              end
            end
            if (!(s_r.atn && attention_mode && !s_r.rx_shift_reg[9])) // RULE9
            begin
              if (s_r.rbf && !rx_read)
              begin
                s_nxt.oe = 1'b1; // RULE25 RULE16
              end
              else
              begin
                s_nxt.rbf = 1'b1; // RULE8 RULE10
                if (fmt == FMT_9)
                begin
                  s_nxt.rbuf = s_r.rx_shift_reg[8:1];
                  s_nxt.rb9 = s_r.rx_shift_reg[9]; // RULE11
                end
                else
                begin
                  s_nxt.rbuf = 8'(s_r.rx_shift_reg >> (4'hA - tot_bits));
                  if (fmt == FMT_7)
                  begin
                    s_nxt.rbuf[7] = 1'b0;
                  end
                end
                if (attention_mode)
                begin
                  s_nxt.atn = 1'b0; // RULE10
                end
              end
              if (!vote)
              begin
                s_nxt.fe = 1'b1; // RULE16
              end
              if (use_par && (par_calc ^ parity_odd))
              begin
                s_nxt.pe = 1'b1; // RULE16
              end
            end
          end
        end
        default:
        begin
          s_nxt.rst_st = RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '0;
      s_r.rx_m <= 1'b1;
      s_r.rx_s <= 1'b1;
      s_r.cts_m <= 1'b1;
      s_r.cts_s <= 1'b1;
      s_r.tst <= TX_IDLE;
      s_r.rst_st <= RX_IDLE;
      s_r.tx_line <= 1'b1;
      s_r.thbe <= 1'b1;
      s_r.rbuf <= RST_DATA;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign txd = diag_mode ? 1'b1 : s_r.tx_line;
  assign rts_n = s_r.thbe; // RULE22
  assign rx_holding_buffer = s_r.rbuf;
  assign rx_ninth_bit = s_r.rb9;
  assign rx_full_flag = s_r.rbf;
  assign tx_holding_empty_flag = s_r.thbe;
  assign tx_in_progress_flag = s_r.tip;
  assign attention_wait_flag = s_r.atn;
  assign parity_err = s_r.pe;
  assign framing_err = s_r.fe;
  assign overrun_err = s_r.oe;
  assign tx_irq = s_r.thbe & tx_irq_enable; // RULE23
  assign rx_irq = s_r.rbf & rx_irq_enable; // RULE24
endmodule : asu_uart
`default_nettype wire

// [asu_uart_sva.sv]
// Port-level assertion checker for the UART
`timescale 1ns/1ps
`default_nettype none
module asu_uart_sva (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic txd,
  input wire logic rts_n,
  input wire logic [4:0] prescaler_select,
  input wire logic diag_mode,
  input wire logic tx_write,
  input wire logic rx_read,
  input wire logic tx_irq_enable,
  input wire logic rx_irq_enable,
  input wire logic [7:0] rx_holding_buffer,
  input wire logic rx_full_flag,
  input wire logic tx_holding_empty_flag,
  input wire logic tx_in_progress_flag,
  input wire logic overrun_err,
  input wire logic tx_irq,
  input wire logic rx_irq
);
  import asu_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_write_clears_empty: assert property (
    tx_write |=> !tx_holding_empty_flag) else $error("empty flag kept after write");
  chk_tx_irq_level: assert property (
    tx_irq == (tx_holding_empty_flag && tx_irq_enable)) else $error("tx irq mismatch");
  chk_rx_irq_level: assert property (
    rx_irq == (rx_full_flag && rx_irq_enable)) else $error("rx irq mismatch");
  chk_rts_when_pending: assert property (
    (!tx_holding_empty_flag) [*2] |-> !rts_n) else $error("rts not asserted");
  chk_busy_held: assert property (
    tx_in_progress_flag && !tx_holding_empty_flag |=> tx_in_progress_flag)
    else $error("busy dropped with pending byte");
  chk_diag_line_high: assert property (
    diag_mode [*2] |-> txd) else $error("txd driven in diagnostic mode");
  chk_stopped_clock: assert property (
    (prescaler_select == PSC_STOP) [*3] |-> $stable(txd)) else $error("txd moved, clock off");
  chk_unread_kept: assert property (
    rx_full_flag && !rx_read |=> $stable(rx_holding_buffer) && rx_full_flag)
    else $error("unread buffer changed");
  cover property (tx_write);
  cover property ($rose(rx_full_flag));
  cover property ($rose(overrun_err));
endmodule : asu_uart_sva
bind asu_uart asu_uart_sva chk_i (.core_clk, .rst, .txd, .rts_n, .prescaler_select, .diag_mode,
  .tx_write, .rx_read, .tx_irq_enable, .rx_irq_enable, .rx_holding_buffer, .rx_full_flag,
  .tx_holding_empty_flag, .tx_in_progress_flag, .overrun_err, .tx_irq, .rx_irq);
`default_nettype wire

// [asu_peer.sv]
// Remote serial peripheral: frame sender, frame catcher, flow control
`timescale 1ns/1ps
`default_nettype none
module asu_peer (
  input wire logic core_clk,
  input wire logic txd,
  output logic rxd,
  output logic cts_n
);
  int bitc = 16;
  initial
  begin
    rxd = 1'h1;
    cts_n = 1'h0;
  end
  task automatic halt(input logic h);
    @(posedge core_clk);
    cts_n <= h;
  endtask : halt
  task automatic send(input logic [12:0] f, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge core_clk);
      rxd <= f[i];
      repeat (bitc - 1) @(posedge core_clk);
    end
    @(posedge core_clk);
    rxd <= 1'h1;
  endtask : send
  task automatic glitch(input int k);
    @(posedge core_clk);
    rxd <= 1'h0;
    repeat (k) @(posedge core_clk);
    rxd <= 1'h1;
  endtask : glitch
  // Mid-bit samples, start bit first
  task automatic grab(output logic [12:0] f, input int n);
    int k;
    f = 13'h0000;
    for (k = 0; k < 4000 && txd !== 1'h0; k++) @(posedge core_clk);
    repeat (bitc / 2) @(posedge core_clk);
    for (int i = 0; i < n; i++)
    begin
      if (i > 0) repeat (bitc) @(posedge core_clk);
      f[i] = txd;
    end
  endtask : grab
endmodule : asu_peer
`default_nettype wire

// [async_serial_uart_tb.sv]
// Self-checking testbench for the UART
`timescale 1ns/1ps
`default_nettype none
module async_serial_uart_tb;
  import asu_pkg::*;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic rxd, txd, cts_n, rts_n, parity_enable, parity_odd, two_stop, attention_mode;
  logic attention_set, diag_mode, manual_sample_select, tx_ninth_bit, tx_write, rx_read;
  logic err_clear, tx_irq_enable, rx_irq_enable, rx_ninth_bit, rx_full_flag, tx_irq, rx_irq;
  logic tx_holding_empty_flag, tx_in_progress_flag, attention_wait_flag;
  logic parity_err, framing_err, overrun_err;
  logic [4:0] prescaler_select;
  logic [10:0] baud_divisor;
  logic [1:0] data_format;
  logic [3:0] sample_position_reg;
  logic [7:0] tx_wdata, rx_holding_buffer;
  int err_total = 0;
  int checks = 0;
  always #20 core_clk = ~core_clk;
  asu_uart uut (.core_clk, .rst, .rxd, .txd, .cts_n, .rts_n, .prescaler_select, .baud_divisor,
    .data_format, .parity_enable, .parity_odd, .two_stop, .attention_mode, .attention_set,
    .diag_mode, .manual_sample_select, .sample_position_reg, .tx_ninth_bit, .tx_wdata,
    .tx_write, .rx_read, .err_clear, .tx_irq_enable, .rx_irq_enable, .rx_holding_buffer,
    .rx_ninth_bit, .rx_full_flag, .tx_holding_empty_flag, .tx_in_progress_flag,
    .attention_wait_flag, .parity_err, .framing_err, .overrun_err, .tx_irq, .rx_irq);
  asu_peer peer (.core_clk, .txd, .rxd, .cts_n);
  task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string m);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("%0d checks, %0d mismatches", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // Frame as sent on the line, start bit at index 0
  function automatic logic [12:0] mk(input logic [8:0] d, input logic [4:0] c, output int n);
    logic [12:0] f;
    logic p;
    f = 13'h0000;
    p = 1'h0;
    n = 1;
    for (int i = 0; i < (c[4:3] == FMT_7 ? 7 : c[4:3] == FMT_8 ? 8 : 9); i++)
    begin
      f[n] = d[i];
      p ^= d[i];
      n++;
    end
    if (c[2] && c[4:3] != FMT_9)
    begin
      f[n] = p ^ c[1];
      n++;
    end
    f[n] = 1'h1;
    f[n + 1] = c[0];
    n = n + 1 + int'(c[0]);
    return f;
  endfunction : mk
  task automatic cfg(input logic [4:0] c);
    @(posedge core_clk);
    {data_format, parity_enable, parity_odd, two_stop} <= c;
  endtask : cfg
  task automatic wr(input logic [7:0] d);
    @(posedge core_clk);
    tx_wdata <= d;
    tx_write <= 1'h1;
    @(posedge core_clk);
    tx_write <= 1'h0;
  endtask : wr
  task automatic pul(input logic [2:0] w);
    @(posedge core_clk);
    {err_clear, attention_set, rx_read} <= w;
    @(posedge core_clk);
    {err_clear, attention_set, rx_read} <= 3'h0;
  endtask : pul
  task automatic wait_full;
    for (int k = 0; k < 4000 && rx_full_flag !== 1'h1; k++) @(posedge core_clk);
  endtask : wait_full
  task automatic wait_idle;
    for (int k = 0; k < 9000 && tx_in_progress_flag !== 1'h0; k++) @(posedge core_clk);
  endtask : wait_idle
  // Two bytes back to back
  task automatic t_tx(input logic [4:0] c, input logic [8:0] d);
    logic [12:0] f;
    int n;
    cfg(c);
    tx_ninth_bit <= d[8];
    wr(d[7:0]);
    #1;
    chk(tx_holding_empty_flag, 1'h0, "empty after write");
    for (int k = 0; k < 99 && tx_holding_empty_flag !== 1'h1; k++) @(posedge core_clk);
    wr(~d[7:0]);
    void'(mk(d, c, n));
    peer.grab(f, n);
    chk(f, mk(d, c, n), "first frame");
    chk({tx_in_progress_flag, tx_holding_empty_flag}, 2'h2, "busy, byte pending");
    void'(mk({d[8], ~d[7:0]}, c, n));
    peer.grab(f, n);
    chk(f, mk({d[8], ~d[7:0]}, c, n), "second frame");
    wait_idle();
    chk(tx_holding_empty_flag, 1'h1, "empty at idle");
    $display("transmit test done");
  endtask : t_tx
  // bad[0] flips parity, bad[1] zeroes stop
  task automatic t_rx(input logic [4:0] c, input logic [8:0] d, input logic [1:0] bad);
    logic [12:0] f;
    int n;
    cfg(c);
    f = mk(d, c, n);
    f[n - 2 - c[0]] ^= bad[0];
    f[n - 1 - c[0]] &= ~bad[1];
    peer.send(f, n);
    wait_full();
    chk({rx_ninth_bit, rx_holding_buffer}, d, "received char");
    chk({framing_err, parity_err}, bad, "error flags");
    pul(3'h5);
    #1;
    chk(rx_full_flag, 1'h0, "full after read");
    $display("receive test done");
  endtask : t_rx
  task automatic t_ovr;
    logic [12:0] f;
    int n;
    cfg({FMT_8, 3'h0});
    peer.send(mk(9'h0a1, {FMT_8, 3'h0}, n), n);
    peer.send(mk(9'h05e, {FMT_8, 3'h0}, n), n);
    for (int k = 0; k < 99 && overrun_err !== 1'h1; k++) @(posedge core_clk);
    chk({overrun_err, rx_holding_buffer}, 9'h1a1, "overrun keeps old");
    pul(3'h5);
    peer.glitch(5);
    repeat (200) @(posedge core_clk);
    chk({rx_full_flag, overrun_err}, 2'h0, "short low rejected");
    $display("overrun test done");
  endtask : t_ovr
  task automatic t_attn;
    int n;
    attention_mode <= 1'h1;
    cfg({FMT_9, 3'h0});
    pul(3'h2);
    peer.send(mk(9'h033, {FMT_9, 3'h0}, n), n);
    repeat (32) @(posedge core_clk);
    chk({attention_wait_flag, rx_full_flag}, 2'h2, "data dropped");
    peer.send(mk(9'h1a5, {FMT_9, 3'h0}, n), n);
    wait_full();
    chk({attention_wait_flag, rx_irq, rx_ninth_bit, rx_holding_buffer}, 11'h3a5, "addr");
    pul(3'h1);
    peer.send(mk(9'h03c, {FMT_9, 3'h0}, n), n);
    wait_full();
    chk({rx_ninth_bit, rx_holding_buffer}, 9'h03c, "data after addr");
    pul(3'h1);
    attention_mode <= 1'h0;
    $display("attention test done");
  endtask : t_attn
  task automatic t_diag;
    diag_mode <= 1'h1;
    cfg({FMT_9, 3'h1});
    tx_ninth_bit <= 1'h1;
    wr(8'h96);
    wait_full();
    chk({txd, rx_ninth_bit, rx_holding_buffer}, 10'h396, "loopback");
    wait_idle();
    pul(3'h1);
    diag_mode <= 1'h0;
    $display("diagnostic test done");
  endtask : t_diag
  task automatic t_cts;
    logic [12:0] f;
    int n;
    cfg({FMT_8, 3'h0});
    tx_irq_enable <= 1'h0;
    peer.halt(1'h1);
    wr(8'h5a);
    repeat (100) @(posedge core_clk);
    chk({txd, tx_holding_empty_flag, rts_n}, 3'h4, "held by flow control");
    peer.halt(1'h0);
    for (int k = 0; k < 99 && txd !== 1'h0; k++) @(posedge core_clk);
    peer.halt(1'h1);
    void'(mk(9'h05a, {FMT_8, 3'h0}, n));
    peer.grab(f, n);
    chk(f, mk(9'h05a, {FMT_8, 3'h0}, n), "frame finishes");
    peer.halt(1'h0);
    tx_irq_enable <= 1'h1;
    wait_idle();
    chk(tx_irq, 1'h1, "tx irq when empty");
    $display("flow control test done");
  endtask : t_cts
  task automatic t_baud;
    logic [12:0] f;
    int n;
    cfg({FMT_8, 3'h0});
    prescaler_select <= PSC_STOP;
    wr(8'hc3);
    repeat (60) @(posedge core_clk);
    chk({txd, tx_holding_empty_flag}, 2'h2, "clock stopped");
    baud_divisor <= 11'h001;
    @(posedge core_clk);
    prescaler_select <= 5'h03;
    peer.bitc = 64;
    void'(mk(9'h0c3, {FMT_8, 3'h0}, n));
    peer.grab(f, n);
    chk(f, mk(9'h0c3, {FMT_8, 3'h0}, n), "divided rate");
    wait_idle();
    prescaler_select <= PSC_STOP;
    @(posedge core_clk);
    baud_divisor <= 11'h000;
    @(posedge core_clk);
    prescaler_select <= 5'h01;
    peer.bitc = 16;
    $display("baud test done");
  endtask : t_baud
  initial
  begin
    {prescaler_select, baud_divisor, data_format, sample_position_reg} = {5'h01, 17'h0};
    {parity_enable, parity_odd, two_stop, attention_mode, attention_set, diag_mode} = 6'h0;
    {manual_sample_select, tx_ninth_bit, tx_write, rx_read, err_clear} = 5'h0;
    {tx_wdata, tx_irq_enable, rx_irq_enable} = {8'h00, 2'h3};
    repeat (10) @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
    #1;
    chk({tx_holding_empty_flag, tx_in_progress_flag, rx_full_flag, rts_n, txd}, 5'h13, "reset");
    t_tx({FMT_7, 3'h4}, 9'h035);
    t_tx({FMT_8, 3'h7}, 9'h0b2);
    t_tx({FMT_9, 3'h4}, 9'h1c9);
    t_rx({FMT_7, 3'h6}, 9'h04d, 2'h0);
    t_rx({FMT_8, 3'h5}, 9'h0e7, 2'h1);
    t_rx({FMT_8, 3'h0}, 9'h081, 2'h2);
    manual_sample_select <= 1'h1;
    sample_position_reg <= 4'h5;
    t_rx({FMT_9, 3'h1}, 9'h16b, 2'h0);
    manual_sample_select <= 1'h0;
    t_ovr();
    t_attn();
    t_diag();
    t_cts();
    t_baud();
    wrap_up();
  end
  initial
  begin
    #3000000;
    err_total++;
    wrap_up();
  end
endmodule : async_serial_uart_tb
`default_nettype wire
